// ==== shared/vareloc_map.vh ====
`ifndef VARELOC_MAP_VH
`define VARELOC_MAP_VH
// Register offsets on the plain register port (word index)
`define VAR_OFF_CTRL     6'h00
`define VAR_OFF_WIDTH    6'h01
`define VAR_OFF_MEMTOP   6'h02
`define VAR_OFF_STATUS   6'h03
`define VAR_OFF_BASE0    6'h10
`define VAR_OFF_DESC0    6'h20
// Field positions
`define VAR_CTRL_RELOC_BIT  0
`define VAR_WIDTH_22_BIT    4
`define VAR_DESC_RO_BIT     0
`define VAR_DESC_VALID_BIT  1
`define VAR_DESC_LEN_LSB    8
`define VAR_DESC_LEN_MSB    14
// Reset value of memory top, and fixed address boundaries
`define VAR_MEMTOP_RST   16'h7fff
`define VAR_IOPAGE_BASE  22'h3fe000
`define VAR_XBUS_BASE    22'h3e0000
`define VAR_VIO_LOW      16'he000
`endif

// ==== logic/vareloc_xlate.v ====
`timescale 1ns/1ps
`default_nettype none
`include "vareloc_map.vh"
// Pure combinational translation of one access
module vareloc_xlate
(
   input wire [15:0] vaddr_i,
   input wire reloc_i,
   input wire wide_i,
   input wire [15:0] base_i,
   input wire [15:0] desc_i,
   input wire is_write_i,
   output reg [21:0] paddr_o,
   output reg fault_o
);
   reg [15:0] sum;
   reg [21:0] pa;
   reg [6:0] len_blk;
   // Base plus block number, offset passes through
   always @*
   begin
      sum = 16'h0000;
      pa = 22'h000000;
      len_blk = desc_i[`VAR_DESC_LEN_MSB:`VAR_DESC_LEN_LSB];
      fault_o = 1'b0;
      if (!reloc_i)
      begin
         if (vaddr_i >= `VAR_VIO_LOW) // R11
            pa = `VAR_IOPAGE_BASE | {9'h000, vaddr_i[12:0]};
         else
            pa = {6'h00, vaddr_i};
      end
      else
      begin
         if (wide_i)
            sum = base_i + {9'h000, vaddr_i[12:6]}; // R20
         else
            sum = {4'h0, base_i[11:0]} + {9'h000, vaddr_i[12:6]};
         pa = {sum, vaddr_i[5:0]}; // R1
         if (!wide_i)
            pa[21:18] = (&pa[17:13]) ? 4'hf : 4'h0; // R19 R13
         if (!desc_i[`VAR_DESC_VALID_BIT]) // R7
            fault_o = 1'b1;
         if (vaddr_i[12:6] > len_blk) // R8
            fault_o = 1'b1;
         if (is_write_i && desc_i[`VAR_DESC_RO_BIT]) // R6
            fault_o = 1'b1;
      end
      paddr_o = pa;
   end
endmodule // vareloc_xlate
`default_nettype wire

// ==== logic/vareloc_top.v ====
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vareloc_map.vh"
// Behaviour
// R1: Translate each 16-bit virtual address to 22-bit physical while relocation active.
// R2: Top 128KW of physical space goes to the expansion bus, offset from zero; code decodes only the top 64KW (from 3e0000) and forwards pa[17:0].
// R3: Top 4KW of that region is the peripheral register page.
// R4: Below memory top is memory; above it up to bus region is nonexistent.
// R5: Virtual space splits into eight 4KW pages, each mapped separately.
// R6: Read-only page refuses writes, permits reads.
// R7: Accesses to pages unmapped in the current mode are refused.
// R8: Page length in 32-word blocks up to 4096; beyond it refused.
// R9: Page base is any 32-word block in physical space.
// R10: Separate kernel and user page register sets.
// R11: Relocation off: pass through, top 8KB virtual goes to peripheral page.
// R12: Reset returns the unit to unrelocated 16-bit mode.
// R13: 22-bit mode reaches all space; 18-bit only low 124KW and peripheral page.
// R14: Compatibility switch off sends every address to the expansion bus too.
// R15: Compatibility forwarding truncates the address to 18 bits.
// R16: Integrator keeps switch on; avoid compatibility with 22-bit relocation.
// R17: Virtual bits 15 to 13 select the page register pair.
// R18: 22-bit needs width bit 4 and control bit 0; width clear gives 18-bit.
// R19: 18-bit: physical bits 17:13 all ones forces 21:18 ones, else zeros.
// R20: 22-bit: full base added to virtual 12:6; bits 5:0 unchanged.
// R21: A violation blocks the bus cycle and signals abort.
// R22: Mode presented with each access selects the register set same cycle.
module vareloc_top
(
   input wire SYS_CLK_I,
   input wire SYS_RST_I,
   input wire [5:0] REG_ADDR_I,
   input wire [15:0] REG_WDATA_I,
   input wire REG_WR_I,
   input wire REG_RD_I,
   output reg [15:0] REG_RDATA_O,
   input wire ACC_REQ_I,
   input wire [15:0] VIRTUAL_ADDR_I,
   input wire ACC_WRITE_I,
   input wire ACC_USER_I,
   input wire COMPAT_ROUTE_SWITCH_I,
   output reg [21:0] PHYSICAL_ADDR_O,
   output reg MEM_SEL_O,
   output reg XBUS_SEL_O,
   output reg [17:0] XBUS_ADDR_O,
   output reg IOPAGE_O,
   output reg NXM_O,
   output reg ABORT_O,
   output reg ACC_DONE_O
);
   localparam PAGES = 8;
   reg [15:0] base_q [0:2*PAGES-1];
   reg [15:0] desc_q [0:2*PAGES-1];
   reg reloc_q;
   reg wide_q;
   reg [15:0] memtop_q;
   reg [1:0] last_q;
   reg sw_s1_q;
   reg sw_s2_q;
   wire [3:0] page_idx;
   wire [21:0] pa;
   wire fault;
   wire in_xbus;
   wire in_io;
   wire in_mem;
   integer i;

   // Switch is a board pin, so resynchronise it
   always @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         sw_s1_q <= 1'b1;
         sw_s2_q <= 1'b1;
      end
      else
      begin
         sw_s1_q <= COMPAT_ROUTE_SWITCH_I;
         sw_s2_q <= sw_s1_q;
      end
   end

   // Mode picks set, top virtual bits pick page
   assign page_idx = {ACC_USER_I, VIRTUAL_ADDR_I[15:13]}; // R10 R17 R22 R5

   vareloc_xlate u_xlate
   (
      .vaddr_i(VIRTUAL_ADDR_I),
      .reloc_i(reloc_q),
      .wide_i(wide_q),
      .base_i(base_q[page_idx]),
      .desc_i(desc_q[page_idx]),
      .is_write_i(ACC_WRITE_I),
      .paddr_o(pa),
      .fault_o(fault)
   );

   // Physical space partition; memtop is in 64-byte blocks
   assign in_xbus = (pa >= `VAR_XBUS_BASE); // R2
   assign in_io = (pa >= `VAR_IOPAGE_BASE); // R3
   assign in_mem = (memtop_q >= pa[21:6]) && !in_xbus; // R4

   // Register writes; base word holds a 32-word block number
   always @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         reloc_q <= 1'b0; // R12
         wide_q <= 1'b0;
         memtop_q <= `VAR_MEMTOP_RST;
         for (i = 0; i < 2*PAGES; i = i + 1)
         begin
            base_q[i] <= 16'h0000;
            desc_q[i] <= 16'h0000;
         end
      end
      else if (REG_WR_I)
      begin
         if (REG_ADDR_I == `VAR_OFF_CTRL)
            reloc_q <= REG_WDATA_I[`VAR_CTRL_RELOC_BIT]; // R18
         else if (REG_ADDR_I == `VAR_OFF_WIDTH)
            wide_q <= REG_WDATA_I[`VAR_WIDTH_22_BIT]; // R18
         else if (REG_ADDR_I == `VAR_OFF_MEMTOP)
            memtop_q <= REG_WDATA_I;
         else if (REG_ADDR_I[5:4] == 2'b01)
            base_q[REG_ADDR_I[3:0]] <= REG_WDATA_I; // R9
         else if (REG_ADDR_I[5:4] == 2'b10)
            desc_q[REG_ADDR_I[3:0]] <= REG_WDATA_I;
      end
   end

   // Read data one cycle after strobe; unmapped reads zero
   always @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         REG_RDATA_O <= 16'h0000;
      else if (REG_RD_I)
      begin
         if (REG_ADDR_I == `VAR_OFF_CTRL)
            REG_RDATA_O <= {15'h0000, reloc_q};
         else if (REG_ADDR_I == `VAR_OFF_WIDTH)
            REG_RDATA_O <= {11'h000, wide_q, 4'h0};
         else if (REG_ADDR_I == `VAR_OFF_MEMTOP)
            REG_RDATA_O <= memtop_q;
         else if (REG_ADDR_I == `VAR_OFF_STATUS)
            REG_RDATA_O <= {14'h0000, last_q};
         else if (REG_ADDR_I[5:4] == 2'b01)
            REG_RDATA_O <= base_q[REG_ADDR_I[3:0]];
         else if (REG_ADDR_I[5:4] == 2'b10)
            REG_RDATA_O <= desc_q[REG_ADDR_I[3:0]];
         else
            REG_RDATA_O <= 16'h0000;
      end
      else
         REG_RDATA_O <= 16'h0000;
   end

   // Registered access result; a fault blocks every select
   always @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         PHYSICAL_ADDR_O <= 22'h000000;
         MEM_SEL_O <= 1'b0;
         XBUS_SEL_O <= 1'b0;
         XBUS_ADDR_O <= 18'h00000;
         IOPAGE_O <= 1'b0;
         NXM_O <= 1'b0;
         ABORT_O <= 1'b0;
         ACC_DONE_O <= 1'b0;
         last_q <= 2'b00;
      end
      else
      begin
         ACC_DONE_O <= ACC_REQ_I;
         PHYSICAL_ADDR_O <= pa;
         XBUS_ADDR_O <= pa[17:0]; // R15
         if (ACC_REQ_I && fault)
         begin
            ABORT_O <= 1'b1; // R21
            MEM_SEL_O <= 1'b0;
            XBUS_SEL_O <= 1'b0;
            IOPAGE_O <= 1'b0;
            NXM_O <= 1'b0;
            last_q <= 2'b01;
         end
         else if (ACC_REQ_I)
         begin
            ABORT_O <= 1'b0;
            // Peripheral page also reaches memory bus for its status words
            MEM_SEL_O <= in_mem || in_io || !sw_s2_q;
            XBUS_SEL_O <= in_xbus || !sw_s2_q; // R2 R14
            IOPAGE_O <= in_io; // R3
            NXM_O <= !in_mem && !in_xbus && sw_s2_q; // R4
            last_q <= {!in_mem && !in_xbus, 1'b0};
         end
         else
         begin
            ABORT_O <= 1'b0;
            MEM_SEL_O <= 1'b0;
            XBUS_SEL_O <= 1'b0;
            IOPAGE_O <= 1'b0;
            NXM_O <= 1'b0;
         end
      end
   end
endmodule // vareloc_top
`default_nettype wire

// ==== dv/vareloc_cpu.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: one access per call
module vareloc_cpu
(
   input wire logic clk_i,
   output logic req_o = 1'b0,
   output logic [15:0] va_o = 16'h5a5a,
   output logic wr_o = 1'b0,
   output logic user_o = 1'b0,
   output logic sw_o = 1'b1
);
   // Mode travels with the address; released bus never shows stale values
   task automatic issue(input logic [15:0] a, input logic w, input logic u);
   begin
      @(posedge clk_i);
      req_o <= 1'b1;
      va_o <= a;
      wr_o <= w;
      user_o <= u;
      @(posedge clk_i);
      req_o <= 1'b0;
      va_o <= ~a;
      wr_o <= ~w;
      user_o <= ~u;
   end
   endtask
endmodule // vareloc_cpu
`default_nettype wire

// ==== dv/vareloc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vareloc_map.vh"
// Access-path checks of the relocator
module vareloc_checker
(
   input wire SYS_CLK_I,
   input wire SYS_RST_I,
   input wire [5:0] REG_ADDR_I,
   input wire [15:0] REG_WDATA_I,
   input wire REG_WR_I,
   input wire ACC_REQ_I,
   input wire [15:0] VIRTUAL_ADDR_I,
   input wire COMPAT_ROUTE_SWITCH_I,
   input wire [21:0] PHYSICAL_ADDR_O,
   input wire MEM_SEL_O,
   input wire XBUS_SEL_O,
   input wire [17:0] XBUS_ADDR_O,
   input wire IOPAGE_O,
   input wire NXM_O,
   input wire ABORT_O,
   input wire ACC_DONE_O
);
   logic reloc_q;
   // Shadow of the enable bit, since the checker cannot see inside
   always @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         reloc_q <= 1'b0;
      else if (REG_WR_I && REG_ADDR_I == `VAR_OFF_CTRL)
         reloc_q <= REG_WDATA_I[0];
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   done_timing_a: assert property (ACC_DONE_O == $past(ACC_REQ_I)) else $error("done misplaced");
   pass_through_a: assert property (ACC_REQ_I && !reloc_q && VIRTUAL_ADDR_I[15:13] != 3'h7
      |=> PHYSICAL_ADDR_O == {6'h00, $past(VIRTUAL_ADDR_I)} && !ABORT_O) else $error("pass bad");
   io_window_a: assert property (ACC_REQ_I && !reloc_q && VIRTUAL_ADDR_I[15:13] == 3'h7
      |=> PHYSICAL_ADDR_O == (22'h3f0000 | {6'h00, $past(VIRTUAL_ADDR_I)})) else $error("window bad");
   xbus_trunc_a: assert property (XBUS_SEL_O |-> XBUS_ADDR_O == PHYSICAL_ADDR_O[17:0]) else $error("trunc");
   abort_block_a: assert property (ABORT_O |-> ACC_DONE_O && !MEM_SEL_O && !XBUS_SEL_O && !NXM_O)
      else $error("abort leak");
   io_page_a: assert property (ACC_DONE_O && !ABORT_O && PHYSICAL_ADDR_O[21:13] == 9'h1ff
      |-> IOPAGE_O && XBUS_SEL_O) else $error("io page");
   nxm_apart_a: assert property (NXM_O |-> !MEM_SEL_O && !XBUS_SEL_O && PHYSICAL_ADDR_O[21:18] != 4'hf)
      else $error("nxm");
   compat_dual_a: assert property (ACC_DONE_O && !ABORT_O && !$past(COMPAT_ROUTE_SWITCH_I, 3)
      |-> MEM_SEL_O && XBUS_SEL_O) else $error("compat");
endmodule // vareloc_checker
bind vareloc_top vareloc_checker u_chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .ACC_REQ_I(ACC_REQ_I), .VIRTUAL_ADDR_I(VIRTUAL_ADDR_I),
   .COMPAT_ROUTE_SWITCH_I(COMPAT_ROUTE_SWITCH_I), .PHYSICAL_ADDR_O(PHYSICAL_ADDR_O), .MEM_SEL_O(MEM_SEL_O),
   .XBUS_SEL_O(XBUS_SEL_O), .XBUS_ADDR_O(XBUS_ADDR_O), .IOPAGE_O(IOPAGE_O), .NXM_O(NXM_O),
   .ABORT_O(ABORT_O), .ACC_DONE_O(ACC_DONE_O));
`default_nettype wire

// ==== dv/virtual_address_relocator_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vareloc_map.vh"
// Self-checking bench
module virtual_address_relocator_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] ra = 6'h00;
   logic [15:0] rwd = 16'h0000;
   logic rw = 1'b0;
   logic rr = 1'b0;
   wire [15:0] rrd, va;
   wire [21:0] pa;
   wire [17:0] xa;
   wire req, wr, us, sw, mem, xb, io, nxm, ab, done;
   int bad_count = 0;
   int checked = 0;
   always #12.5 clk = ~clk;
   vareloc_cpu cpu (.clk_i(clk), .req_o(req), .va_o(va), .wr_o(wr), .user_o(us), .sw_o(sw));
   vareloc_top DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(ra), .REG_WDATA_I(rwd), .REG_WR_I(rw),
      .REG_RD_I(rr), .REG_RDATA_O(rrd), .ACC_REQ_I(req), .VIRTUAL_ADDR_I(va), .ACC_WRITE_I(wr),
      .ACC_USER_I(us), .COMPAT_ROUTE_SWITCH_I(sw), .PHYSICAL_ADDR_O(pa), .MEM_SEL_O(mem), .XBUS_SEL_O(xb),
      .XBUS_ADDR_O(xa), .IOPAGE_O(io), .NXM_O(nxm), .ABORT_O(ab), .ACC_DONE_O(done));
   task stop_test;
   begin
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk(input logic [21:0] got, input logic [21:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task wreg(input logic [5:0] a, input logic [15:0] d);
   begin
      @(posedge clk);
      ra <= a;
      rwd <= d;
      rw <= 1'b1;
      @(posedge clk);
      rw <= 1'b0;
   end
   endtask
   task rreg(input logic [5:0] a, input logic [15:0] e);
   begin
      @(posedge clk);
      ra <= a;
      rr <= 1'b1;
      @(posedge clk);
      rr <= 1'b0;
      #1 chk({6'h00, rrd}, {6'h00, e});
   end
   endtask
   // Flags are mem, xbus, io page, nxm, abort; address judged only when not aborted
   task acc(input logic [15:0] a, input logic w, input logic u, input logic [21:0] ep, input logic [4:0] ef);
   begin
      cpu.issue(a, w, u);
      #1 chk({16'h0000, done, mem, xb, io, nxm, ab}, {16'h0000, 1'b1, ef});
      if (!ef[0])
      begin
         chk(pa, ep);
         chk({4'h0, xa}, {4'h0, ep[17:0]});
      end
   end
   endtask
   task t_reset;
   begin
      rreg(`VAR_OFF_CTRL, 16'h0000);
      rreg(`VAR_OFF_MEMTOP, `VAR_MEMTOP_RST);
      rreg(6'h3f, 16'h0000);
      acc(16'h1234, 1'b0, 1'b0, 22'h001234, 5'b10000);
      acc(16'hfffe, 1'b1, 1'b1, 22'h3ffffe, 5'b11100);
   end
   endtask
   // Eighteen-bit mapping: masking, forcing, protection
   task t_reloc18;
   begin
      wreg(`VAR_OFF_CTRL, 16'h0001);
      wreg(`VAR_OFF_BASE0, 16'h1001);
      wreg(`VAR_OFF_DESC0, 16'h7f02);
      wreg(`VAR_OFF_BASE0 + 6'h07, 16'h0f80);
      wreg(`VAR_OFF_DESC0 + 6'h07, 16'h7f02);
      wreg(`VAR_OFF_DESC0 + 6'h01, 16'h7f03);
      wreg(`VAR_OFF_DESC0 + 6'h02, 16'h0102);
      acc(16'h0044, 1'b0, 1'b0, 22'h000084, 5'b10000);
      acc(16'h0044, 1'b0, 1'b1, 22'h000000, 5'b00001);
      wreg(`VAR_OFF_BASE0 + 6'h08, 16'h0002);
      wreg(`VAR_OFF_DESC0 + 6'h08, 16'h7f02);
      acc(16'h0000, 1'b0, 1'b1, 22'h000080, 5'b10000);
      acc(16'he000, 1'b0, 1'b0, 22'h3fe000, 5'b11100);
      acc(16'h2000, 1'b1, 1'b0, 22'h000000, 5'b00001);
      acc(16'h2000, 1'b0, 1'b0, 22'h000000, 5'b10000);
      acc(16'h4040, 1'b0, 1'b0, 22'h000040, 5'b10000);
      acc(16'h4080, 1'b0, 1'b0, 22'h000000, 5'b00001);
      rreg(`VAR_OFF_STATUS, 16'h0001);
      rreg(`VAR_OFF_BASE0 + 6'h07, 16'h0f80);
   end
   endtask
   // Mid-run reset must drop back to pass-through
   task t_rereset;
   begin
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rreg(`VAR_OFF_CTRL, 16'h0000);
      acc(16'h1234, 1'b0, 1'b0, 22'h001234, 5'b10000);
   end
   endtask
   // Switch off: every address also reaches the expansion bus
   task t_compat;
   begin
      cpu.sw_o <= 1'b0;
      repeat (4) @(posedge clk);
      acc(16'h0044, 1'b0, 1'b0, 22'h000084, 5'b11000);
      cpu.sw_o <= 1'b1;
      repeat (4) @(posedge clk);
   end
   endtask
   task t_reloc22;
   begin
      wreg(`VAR_OFF_WIDTH, 16'h0010);
      wreg(`VAR_OFF_BASE0, 16'hf800);
      acc(16'h0044, 1'b0, 1'b0, 22'h3e0044, 5'b01000);
      rreg(`VAR_OFF_WIDTH, 16'h0010);
      wreg(`VAR_OFF_BASE0 + 6'h03, 16'h8000);
      wreg(`VAR_OFF_DESC0 + 6'h03, 16'h7f02);
      acc(16'h6000, 1'b0, 1'b0, 22'h200000, 5'b00010);
      rreg(`VAR_OFF_STATUS, 16'h0002);
   end
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_reloc18;
      t_compat;
      t_reloc22;
      t_rereset;
      stop_test;
   end
   // Hang guard
   initial
   begin
      #2000000;
      bad_count++;
      stop_test;
   end
endmodule // virtual_address_relocator_tb
`default_nettype wire
